// ---- verilog/srpc_pkg.sv ----
/*
  Package for the system reset and power control block: register map,
  field positions, reset values, timing constants and carrier structs.
  Assumes a single 125 MHz clock and a 32-bit Avalon-MM register port.
*/
package srpc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int PIN_RST_MIN_NS = 50;
  // rounds down: an async pulse of the least width always spans this many edges
  localparam int PIN_RST_CYC_RAW = (PIN_RST_MIN_NS * 1000) / CLK_PERIOD_PS;
  localparam int PIN_RST_CYC = (PIN_RST_CYC_RAW < 1) ? 1 : PIN_RST_CYC_RAW;
  localparam int RST_STRETCH_CYC = 4;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BROWNOUT = 8'h08;
  localparam logic [7:0] REG_PROTECT = 8'h0C;
  localparam logic [7:0] REG_CLKSEL = 8'h10;
  localparam logic [7:0] REG_RSTSRC = 8'h14;

  // control register fields
  localparam int CTRL_DPD_REQ_BIT = 0;
  localparam int CTRL_DPD_LOCK_BIT = 1;
  localparam int CTRL_BOOT_PIN_DIS_BIT = 2;

  // brownout register fields
  localparam int BO_IRQ_LVL_LSB = 0;
  localparam int BO_RST_LVL_LSB = 4;
  localparam int BO_RST_EN_BIT = 8;
  localparam int BO_IRQ_EN_BIT = 9;

  // reset values
  localparam logic [1:0] BO_IRQ_LVL_RST = 2'h0;
  localparam logic [1:0] BO_RST_LVL_RST = 2'h0;
  localparam logic [1:0] CLKSEL_RST = 2'h0;
  localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;

  // protection pattern words; the values are arbitrary
  localparam logic [31:0] PROT_PAT_ONE = 32'hA5C3_0001;
  localparam logic [31:0] PROT_PAT_TWO = 32'hA5C3_0002;
  localparam logic [31:0] PROT_PAT_THREE = 32'hA5C3_0003;
  localparam logic [31:0] PROT_PAT_NOBOOT = 32'hA5C3_00B0;

  // debug resources
  localparam int NUM_BREAKPOINTS = 4;
  localparam int NUM_WATCHPOINTS = 2;

  // test access
  typedef enum logic {TAM_BOUNDARY_SCAN, TAM_SERIAL_DEBUG} srpc_tam_t;

  typedef enum logic [1:0] {PROT_NONE, PROT_ONE, PROT_TWO, PROT_THREE} srpc_prot_t;

  // reset source flags: pin, watchdog, power-on, brownout
  typedef struct packed {
    logic pin;
    logic wdog;
    logic por;
    logic brownout;
  } srpc_rst_src_t;

  // access permissions granted by protection
  typedef struct packed {
    logic swd_en;
    logic prog_en;
    logic prog_limited;
    logic prog_erase_only;
    logic prog_sector0_ok;
    logic boot_pin_en;
    logic app_prog_en;
  } srpc_access_t;

endpackage : srpc_pkg

// ---- verilog/srpc_top.sv ----
/*
  System reset and power control: reset merge and stretch, deepest
  power-down entry and wake, brownout compare, read protection decode,
  test access mode selection and an Avalon-MM register slave.
  Assumes all pins and the analog brownout level code are asynchronous;
  power-on detection arrives as an active-high level.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
// Functional notes
// - deepest power-down kills all; wake pin only
// - lock bit refuses deepest power-down entry
// - four reset sources: pin, watchdog, POR, brownout
// - chip reset starts RC oscillator, inits flash
// - reset pin low 50 ns resets device
// - released reset: defaults set, fetch at zero
// - brownout interrupt while supply below level
// - interrupt gated by enable; raw always readable
// - software picks one of four reset thresholds
// - flash pattern sets protection; application programming free
// - boot-select programming entry disabled independently
// - level one: no debug, no sector zero
// - level two: no debug, erase-all programming only
// - level three: no debug, no programming, no boot pin
// - reset pin low boundary scan, high serial debug
// - serial debug disabled while in reset
// - boundary scan offers no processor debug
// - four breakpoints, two watchpoints
// - runs from RC oscillator after any reset
module srpc_top
  import srpc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // pins and sources
  input wire logic reset_pin_n_in,
  input wire logic wake_pin_in,
  input wire logic wdog_reset_in,
  input wire logic por_in,
  input wire logic [2:0] supply_level_in,
  input wire logic [31:0] protect_word_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // system outputs
  output logic chip_reset_out,
  output logic rc_osc_start_out,
  output logic flash_init_out,
  output logic [31:0] fetch_addr_out,
  output logic [1:0] clk_sel_out,
  output logic power_domain_en_out,
  output logic brownout_irq_out,
  output logic brownout_irq_gated_out,
  output logic swd_enable_out,
  output logic bscan_enable_out,
  output srpc_access_t access_out,
  output logic [2:0] num_breakpoints_out,
  output logic [1:0] num_watchpoints_out
);

  typedef enum {ST_RUN, ST_DEEP_DOWN} srpc_pwr_st_t;

  // synchronisers
  logic [1:0] rst_pin_sync_r;
  logic [1:0] wake_sync_r;
  logic [1:0] wdog_sync_r;
  logic [1:0] por_sync_r;
  logic [2:0] lvl_s1_r;
  logic [2:0] lvl_s2_r;
  logic [2:0] lvl_s3_r;
  logic [2:0] lvl_r;

  always_ff @(posedge clock_in)
  begin
    rst_pin_sync_r <= {rst_pin_sync_r[0], reset_pin_n_in};
    wake_sync_r <= {wake_sync_r[0], wake_pin_in};
    wdog_sync_r <= {wdog_sync_r[0], wdog_reset_in};
    por_sync_r <= {por_sync_r[0], por_in};
    lvl_s1_r <= supply_level_in;
    lvl_s2_r <= lvl_s1_r;
    lvl_s3_r <= lvl_s2_r;
    // code bits may land on different edges; take a code once it repeats
    if (lvl_s3_r == lvl_s2_r)
      lvl_r <= lvl_s3_r;
  end

  logic pin_low;
  assign pin_low = ~rst_pin_sync_r[1];

  // registers
  logic dpd_lock_r;
  logic boot_pin_dis_r;
  logic [1:0] bo_irq_lvl_r;
  logic [1:0] bo_rst_lvl_r;
  logic bo_rst_en_r;
  logic bo_irq_en_r;
  logic [1:0] clk_sel_r;
  srpc_rst_src_t rst_flags_r;
  srpc_pwr_st_t pwr_st_r;
  srpc_prot_t prot_r;
  logic boot_dis_flash_r;

  // pin low filter: glitches spanning fewer than PIN_RST_CYC clock edges are ignored
  logic [7:0] pin_cnt_r;
  logic pin_rst_r;
  always_ff @(posedge clock_in)
  begin
    if (srst_in || !pin_low)
    begin
      pin_cnt_r <= 8'h00;
      pin_rst_r <= 1'b0;
    end
    else if (pin_cnt_r < 8'(PIN_RST_CYC - 1))
      pin_cnt_r <= pin_cnt_r + 8'h01;
    else
      pin_rst_r <= 1'b1;
  end

  // brownout compare; level code below the selected threshold means low supply
  logic bo_irq_raw;
  logic bo_rst_req;
  assign bo_irq_raw = lvl_r < {1'b0, bo_irq_lvl_r};
  assign bo_rst_req = bo_rst_en_r && (lvl_r < {1'b0, bo_rst_lvl_r});

  srpc_rst_src_t src_now;
  assign src_now = '{pin: pin_rst_r, wdog: wdog_sync_r[1], por: por_sync_r[1],
                     brownout: bo_rst_req};

  // stretch keeps reset until every source released plus a few cycles
  logic [2:0] stretch_r;
  logic chip_rst_r;
  always_ff @(posedge clock_in)
  begin
    if (srst_in || (|src_now))
    begin
      stretch_r <= 3'(RST_STRETCH_CYC);
      chip_rst_r <= 1'b1;
    end
    else if (stretch_r != 3'h0)
      stretch_r <= stretch_r - 3'h1;
    else
      chip_rst_r <= 1'b0;
  end

  // reset cause flags: set wins over software clear
  logic src_clr;
  assign src_clr = avs_write && !avs_waitrequest && avs_address == REG_RSTSRC
                   && avs_byteenable[0];
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      rst_flags_r <= '0;
    else
      rst_flags_r <= (src_clr ? (rst_flags_r & ~srpc_rst_src_t'(avs_writedata[3:0]))
                             : rst_flags_r) | src_now;
  end

  // deepest power-down state machine
  logic dpd_req;
  assign dpd_req = avs_write && !avs_waitrequest && avs_address == REG_CTRL
                   && avs_byteenable[0] && avs_writedata[CTRL_DPD_REQ_BIT];
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      pwr_st_r <= ST_RUN;
    else
    begin
      unique case (pwr_st_r)
        ST_RUN:
          if (dpd_req && !dpd_lock_r && !chip_rst_r)
            pwr_st_r <= ST_DEEP_DOWN;
        ST_DEEP_DOWN:
          if (!wake_sync_r[1])
            pwr_st_r <= ST_RUN;
      endcase
    end
  end

  logic in_dpd;
  assign in_dpd = pwr_st_r == ST_DEEP_DOWN;

  // software registers; all return to defaults under chip reset
  logic reg_wr;
  assign reg_wr = avs_write && !avs_waitrequest;
  always_ff @(posedge clock_in)
  begin
    if (srst_in || chip_rst_r || in_dpd)
    begin
      dpd_lock_r <= 1'b0;
      boot_pin_dis_r <= 1'b0;
      bo_irq_lvl_r <= BO_IRQ_LVL_RST;
      bo_rst_lvl_r <= BO_RST_LVL_RST;
      bo_rst_en_r <= 1'b0;
      bo_irq_en_r <= 1'b0;
      clk_sel_r <= CLKSEL_RST;
    end
    else if (reg_wr)
    begin
      unique case (avs_address)
        REG_CTRL:
          if (avs_byteenable[0])
          begin
            dpd_lock_r <= dpd_lock_r | avs_writedata[CTRL_DPD_LOCK_BIT];
            boot_pin_dis_r <= avs_writedata[CTRL_BOOT_PIN_DIS_BIT];
          end
        REG_BROWNOUT:
        begin
          if (avs_byteenable[0])
          begin
            bo_irq_lvl_r <= avs_writedata[BO_IRQ_LVL_LSB +: 2];
            bo_rst_lvl_r <= avs_writedata[BO_RST_LVL_LSB +: 2];
          end
          if (avs_byteenable[1])
          begin
            bo_rst_en_r <= avs_writedata[BO_RST_EN_BIT];
            bo_irq_en_r <= avs_writedata[BO_IRQ_EN_BIT];
          end
        end
        REG_CLKSEL:
          if (avs_byteenable[0])
            clk_sel_r <= avs_writedata[1:0];
        default:
          ;
      endcase
    end
  end

  // protection level caught from flash pattern at reset release
  function automatic srpc_prot_t prot_decode(input logic [31:0] w);
    unique case (w)
      PROT_PAT_ONE: prot_decode = PROT_ONE;
      PROT_PAT_TWO: prot_decode = PROT_TWO;
      PROT_PAT_THREE: prot_decode = PROT_THREE;
      default: prot_decode = PROT_NONE;
    endcase
  endfunction : prot_decode

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      prot_r <= PROT_NONE;
      boot_dis_flash_r <= 1'b0;
    end
    else if (chip_rst_r)
    begin
      prot_r <= prot_decode(protect_word_in);
      boot_dis_flash_r <= protect_word_in == PROT_PAT_NOBOOT;
    end
  end

  srpc_access_t acc;
  always_comb
  begin
    acc.app_prog_en = 1'b1;
    acc.swd_en = prot_r == PROT_NONE;
    acc.prog_en = prot_r != PROT_THREE;
    acc.prog_limited = prot_r == PROT_ONE;
    acc.prog_erase_only = prot_r == PROT_TWO;
    acc.prog_sector0_ok = prot_r == PROT_NONE || prot_r == PROT_TWO;
    acc.boot_pin_en = prot_r != PROT_THREE && !boot_pin_dis_r && !boot_dis_flash_r;
  end

  // outputs
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      access_out <= '0;
      swd_enable_out <= 1'b0;
      bscan_enable_out <= 1'b0;
      brownout_irq_out <= 1'b0;
      brownout_irq_gated_out <= 1'b0;
    end
    else
    begin
      access_out <= acc;
      // tam by pin level; debug only while out of reset
      bscan_enable_out <= pin_low;
      // source term drops debug on the very edge that raises chip reset
      swd_enable_out <= !pin_low && !chip_rst_r && !(|src_now) && !in_dpd
                        && acc.swd_en;
      brownout_irq_out <= bo_irq_raw && !chip_rst_r;
      brownout_irq_gated_out <= bo_irq_raw && bo_irq_en_r && !chip_rst_r;
    end
  end

  assign chip_reset_out = chip_rst_r;
  assign rc_osc_start_out = chip_rst_r || clk_sel_r == CLKSEL_RST;
  assign flash_init_out = chip_rst_r;
  assign fetch_addr_out = BOOT_VECTOR;
  assign clk_sel_out = clk_sel_r;
  assign power_domain_en_out = !in_dpd;
  assign num_breakpoints_out = 3'(NUM_BREAKPOINTS);
  assign num_watchpoints_out = 2'(NUM_WATCHPOINTS);

  // bus: reads take one wait cycle so data comes from flops
  logic rd_done_r;
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      rd_done_r <= 1'b0;
    else
      rd_done_r <= avs_read && !rd_done_r;
  end
  assign avs_waitrequest = avs_read && !rd_done_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == REG_CTRL || a == REG_STATUS || a == REG_BROWNOUT
             || a == REG_PROTECT || a == REG_CLKSEL || a == REG_RSTSRC;
  endfunction : mapped

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end
    else if (avs_read && !rd_done_r)
    begin
      avs_response <= mapped(avs_address) ? 2'h0 : 2'h3;
      unique case (avs_address)
        REG_CTRL: avs_readdata <= {29'h0, boot_pin_dis_r, dpd_lock_r, 1'b0};
        REG_STATUS: avs_readdata <= {28'h0, lvl_r, bo_irq_raw};
        REG_BROWNOUT: avs_readdata <= {22'h0, bo_irq_en_r, bo_rst_en_r, 2'h0,
                                       bo_rst_lvl_r, 2'h0, bo_irq_lvl_r};
        REG_PROTECT: avs_readdata <= {22'h0, prot_r, acc, prot_r != PROT_NONE};
        REG_CLKSEL: avs_readdata <= {30'h0, clk_sel_r};
        REG_RSTSRC: avs_readdata <= {28'h0, rst_flags_r};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // assertions
  a_lock_blocks_dpd: assert property (@(posedge clock_in) disable iff (srst_in)
    (pwr_st_r == ST_RUN && dpd_lock_r) |=> pwr_st_r == ST_RUN)
    else $error("deep power-down entered while locked");

  sequence s_src_active;
    |src_now;
  endsequence
  a_reset_merge: assert property (@(posedge clock_in) disable iff (srst_in)
    s_src_active |=> chip_rst_r)
    else $error("chip reset not asserted for active source");

  a_reset_hold: assert property (@(posedge clock_in) disable iff (srst_in)
    $fell(chip_rst_r) |-> $past(src_now, 1) == '0)
    else $error("chip reset released while a source active");

  sequence s_pin_held;
    pin_low [*8];
  endsequence
  a_pin_reset: assert property (@(posedge clock_in) disable iff (srst_in)
    s_pin_held |-> ##[1:2] chip_rst_r)
    else $error("long reset pin pulse did not reset");

  a_swd_in_reset: assert property (@(posedge clock_in) disable iff (srst_in)
    chip_rst_r |-> !swd_enable_out)
    else $error("serial debug enabled during reset");

  a_bscan_by_pin: assert property (@(posedge clock_in) disable iff (srst_in)
    pin_low |=> bscan_enable_out && !swd_enable_out)
    else $error("test access mode does not follow pin");

  a_irq_gating: assert property (@(posedge clock_in) disable iff (srst_in)
    brownout_irq_gated_out |-> brownout_irq_out && $past(bo_irq_en_r, 1))
    else $error("brownout interrupt passed while disabled");

  a_level3_blocks: assert property (@(posedge clock_in) disable iff (srst_in)
    prot_r == PROT_THREE |=> !access_out.prog_en && !access_out.boot_pin_en
    && !access_out.swd_en)
    else $error("level three left access open");

  a_dpd_wake: assert property (@(posedge clock_in) disable iff (srst_in)
    (in_dpd && wake_sync_r[1]) |=> in_dpd && !power_domain_en_out)
    else $error("left deep power-down without wake pin");

  a_clock_default: assert property (@(posedge clock_in) disable iff (srst_in)
    $fell(chip_rst_r) |-> clk_sel_r == CLKSEL_RST)
    else $error("clock select not default after reset");

endmodule : srpc_top

// ---- verif/srpc_far_side.sv ----
/*
  Far-side model: board and boundary-scan tester on the reset and wake pins.
  Assumes the shared system clock; both pins idle high through pull-ups.
*/
module srpc_far_side #(
  // 250 us at 8 ns
  parameter int BSCAN_WAIT_CYC = 31250
)(
  // clock
  input wire logic clock_in,
  // pins
  output logic reset_pin_n_out,
  output logic wake_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // pull-ups hold both pins high when nobody drives them
  initial
  begin
    reset_pin_n_out = 1'b1;
    wake_pin_out = 1'b1;
  end

  task automatic drive_reset(input logic v);
    @(posedge clock_in);
    reset_pin_n_out <= v;
  endtask : drive_reset

  task automatic pulse_reset(input int cyc);
    drive_reset(1'b0);
    repeat (cyc - 1) @(posedge clock_in);
    drive_reset(1'b1);
  endtask : pulse_reset

  task automatic wake_pulse(input int cyc);
    @(posedge clock_in);
    wake_pin_out <= 1'b0;
    repeat (cyc) @(posedge clock_in);
    wake_pin_out <= 1'b1;
  endtask : wake_pulse

  // pin high through the settle wait, then low to select scan
  task automatic bscan_enter();
    drive_reset(1'b1);
    repeat (BSCAN_WAIT_CYC) @(posedge clock_in);
    drive_reset(1'b0);
  endtask : bscan_enter

endmodule : srpc_far_side

// ---- verif/srpc_top_tb.sv ----
/*
  Self-checking bench for srpc_top: bus tasks, one task per scenario.
  Assumes the far-side model drives the reset and wake pins.
*/
module srpc_top_tb;
  import srpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_in, srst_in, wdog_reset_in, por_in, reset_pin_n, wake_pin;
  logic [2:0] supply_level_in;
  logic [31:0] protect_word_in, avs_writedata, avs_readdata, fetch_addr_out, rd;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, chip_reset_out, rc_osc_start_out;
  logic flash_init_out, power_domain_en_out, brownout_irq_out, brownout_irq_gated_out;
  logic swd_enable_out, bscan_enable_out;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, clk_sel_out, num_watchpoints_out, rsp;
  logic [2:0] num_breakpoints_out;
  srpc_access_t access_out;
  int failures, total_checks, n;
  logic [31:0] pats [5];

  srpc_top i_srpc_top (.clock_in(clock_in), .srst_in(srst_in),
    .reset_pin_n_in(reset_pin_n), .wake_pin_in(wake_pin), .wdog_reset_in(wdog_reset_in),
    .por_in(por_in), .supply_level_in(supply_level_in), .protect_word_in(protect_word_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .chip_reset_out(chip_reset_out),
    .rc_osc_start_out(rc_osc_start_out), .flash_init_out(flash_init_out),
    .fetch_addr_out(fetch_addr_out), .clk_sel_out(clk_sel_out),
    .power_domain_en_out(power_domain_en_out), .brownout_irq_out(brownout_irq_out),
    .brownout_irq_gated_out(brownout_irq_gated_out), .swd_enable_out(swd_enable_out),
    .bscan_enable_out(bscan_enable_out), .access_out(access_out),
    .num_breakpoints_out(num_breakpoints_out), .num_watchpoints_out(num_watchpoints_out));

  srpc_far_side i_srpc_far_side (.clock_in(clock_in), .reset_pin_n_out(reset_pin_n),
    .wake_pin_out(wake_pin));

  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s: got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // waits as long as the slave stalls; only the watchdog ends a hang
  task automatic bus_wait();
    do @(posedge clock_in); while (avs_waitrequest !== 1'b0);
    chk_bit(avs_waitrequest, 1'b0, "bus answer");
  endtask : bus_wait

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a);
    @(posedge clock_in);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
  endtask : bus_rd

  task automatic wait_rst(input logic v);
    for (n = 0; n < 200 && chip_reset_out !== v; n++)
      @(posedge clock_in);
    chk_bit(chip_reset_out, v, "chip reset");
  endtask : wait_rst

  task automatic do_srst();
    @(posedge clock_in);
    srst_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    srst_in <= 1'b0;
    wait_rst(1'b0);
    // debug enable trails the reset release by one flop
    @(posedge clock_in);
  endtask : do_srst

  task automatic t_defaults();
    chk_word(fetch_addr_out, 32'h0000_0000, "fetch");
    chk_word({30'h0, clk_sel_out}, 32'h0, "clk sel");
    chk_bit(rc_osc_start_out, 1'b1, "osc");
    chk_word({29'h0, num_breakpoints_out}, 32'h4, "bkpt");
    chk_word({30'h0, num_watchpoints_out}, 32'h2, "wpt");
    chk_bit(swd_enable_out, 1'b1, "swd");
    chk_bit(bscan_enable_out, 1'b0, "bscan");
    bus_rd(REG_CTRL);
    chk_word(rd, 32'h0, "ctrl rst");
    bus_rd(8'hFC);
    chk_word({rsp, rd[29:0]}, 32'hC000_0000, "unmapped");
  endtask : t_defaults

  // k: 0 watchdog, 1 power-on, 2 pin, 3 brownout
  task automatic src_case(input int k);
    bus_wr(REG_CLKSEL, 32'h0000_0001);
    @(posedge clock_in);
    chk_bit(rc_osc_start_out, 1'b0, "osc off");
    if (k == 3)
      bus_wr(REG_BROWNOUT, 32'h0000_0130);
    case (k)
      0: wdog_reset_in <= 1'b1;
      1: por_in <= 1'b1;
      2: i_srpc_far_side.drive_reset(1'b0);
      default: supply_level_in <= 3'h2;
    endcase
    wait_rst(1'b1);
    chk_bit(flash_init_out, 1'b1, "flash init");
    chk_bit(rc_osc_start_out, 1'b1, "osc on");
    chk_bit(swd_enable_out, 1'b0, "swd in reset");
    repeat (20) @(posedge clock_in);
    if (k < 3)
      chk_bit(chip_reset_out, 1'b1, "held");
    wdog_reset_in <= 1'b0;
    por_in <= 1'b0;
    supply_level_in <= 3'h7;
    if (k == 2)
      i_srpc_far_side.drive_reset(1'b1);
    wait_rst(1'b0);
    chk_word({30'h0, clk_sel_out}, 32'h0, "clk after rst");
    bus_rd(REG_RSTSRC);
    chk_bit(rd[(k == 0) ? 2 : (k == 1) ? 1 : (k == 2) ? 3 : 0], 1'b1, "cause flag");
    bus_wr(REG_RSTSRC, 32'h0000_000F);
    bus_rd(REG_RSTSRC);
    chk_word(rd, 32'h0, "cause clear");
  endtask : src_case

  task automatic t_brownout_irq();
    bus_wr(REG_BROWNOUT, 32'h0000_0003);
    supply_level_in <= 3'h1;
    for (n = 0; n < 50 && brownout_irq_out !== 1'b1; n++)
      @(posedge clock_in);
    chk_bit(brownout_irq_out, 1'b1, "raw");
    chk_bit(brownout_irq_gated_out, 1'b0, "gated off");
    bus_rd(REG_STATUS);
    chk_bit(rd[0], 1'b1, "status raw");
    bus_wr(REG_BROWNOUT, 32'h0000_0203);
    for (n = 0; n < 50 && brownout_irq_gated_out !== 1'b1; n++)
      @(posedge clock_in);
    chk_bit(brownout_irq_gated_out, 1'b1, "gated on");
    supply_level_in <= 3'h7;
    for (n = 0; n < 50 && brownout_irq_out !== 1'b0; n++)
      @(posedge clock_in);
    chk_bit(brownout_irq_out, 1'b0, "raw clear");
  endtask : t_brownout_irq

  task automatic t_pin_pulse();
    i_srpc_far_side.pulse_reset(7);
    wait_rst(1'b1);
    wait_rst(1'b0);
  endtask : t_pin_pulse

  task automatic t_power_down();
    bus_wr(REG_CLKSEL, 32'h0000_0002);
    bus_wr(REG_CTRL, 32'h0000_0001);
    for (n = 0; n < 50 && power_domain_en_out !== 1'b0; n++)
      @(posedge clock_in);
    chk_bit(power_domain_en_out, 1'b0, "dpd in");
    i_srpc_far_side.wake_pulse(3);
    for (n = 0; n < 50 && power_domain_en_out !== 1'b1; n++)
      @(posedge clock_in);
    chk_bit(power_domain_en_out, 1'b1, "dpd out");
    wait_rst(1'b0);
    chk_word({30'h0, clk_sel_out}, 32'h0, "clk after wake");
    bus_wr(REG_CTRL, 32'h0000_0002);
    bus_wr(REG_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clock_in);
    chk_bit(power_domain_en_out, 1'b1, "locked");
  endtask : t_power_down

  // none, one, two, three, boot pin only
  task automatic t_protect();
    pats = '{32'h0, PROT_PAT_ONE, PROT_PAT_TWO, PROT_PAT_THREE, PROT_PAT_NOBOOT};
    for (int lv = 0; lv < 5; lv++)
    begin
      protect_word_in <= pats[lv];
      do_srst();
      chk_bit(access_out.swd_en, lv == 0 || lv == 4, "swd");
      chk_bit(swd_enable_out, lv == 0 || lv == 4, "swd pin");
      chk_bit(access_out.prog_en, lv != 3, "prog");
      chk_bit(access_out.boot_pin_en, lv < 3, "boot pin");
      chk_bit(access_out.app_prog_en, 1'b1, "app prog");
      chk_bit(access_out.prog_limited, lv == 1, "limited");
      if (lv == 1)
        chk_bit(access_out.prog_sector0_ok, 1'b0, "sector0");
      if (lv == 2)
        chk_bit(access_out.prog_erase_only, 1'b1, "erase only");
      bus_rd(REG_PROTECT);
      chk_word({30'h0, rd[9:8]}, (lv == 4) ? 32'h0 : 32'(lv), "prot level");
    end
    protect_word_in <= 32'h0;
    do_srst();
  endtask : t_protect

  task automatic t_bscan();
    i_srpc_far_side.bscan_enter();
    for (n = 0; n < 50 && bscan_enable_out !== 1'b1; n++)
      @(posedge clock_in);
    chk_bit(bscan_enable_out, 1'b1, "scan sel");
    chk_bit(swd_enable_out, 1'b0, "no debug in scan");
    i_srpc_far_side.drive_reset(1'b1);
    wait_rst(1'b0);
    for (n = 0; n < 50 && swd_enable_out !== 1'b1; n++)
      @(posedge clock_in);
    chk_bit(swd_enable_out, 1'b1, "swd back");
    chk_bit(bscan_enable_out, 1'b0, "scan off");
  endtask : t_bscan

  initial
  begin
    srst_in = 1'b1;
    wdog_reset_in = 1'b0;
    por_in = 1'b0;
    supply_level_in = 3'h7;
    protect_word_in = 32'h0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    failures = 0;
    total_checks = 0;
    do_srst();
    t_defaults();
    for (int k = 0; k < 4; k++)
      src_case(k);
    t_brownout_irq();
    t_pin_pulse();
    t_power_down();
    t_protect();
    t_bscan();
    give_verdict();
  end

  // whole run is near 32k cycles; allow 60k
  initial
  begin
    #480000;
    failures++;
    give_verdict();
  end

endmodule : srpc_top_tb
